/* File: inc/srb_cfg.svh */
/*
  Constants for the serial receiver self-test and mode logic: character
  codes, counter limits and host sequencing counts.
  Assumes it is included by bare name wherever these macros are read.
*/
// Notes on behaviour
// R1 - host drops enable, awaits first ready low
// R2 - violation high on each mismatching byte
// R3 - ready pulses high once per pattern loop
// R4 - expected pattern shown on byte outputs
// R5 - host raises enable, normal mode resumes
// R6 - deliberate pattern violations drive violation high
// R7 - transmitter sends violations before self-test
// R8 - bypass plus self-test forces decoded checking
// R9 - mode pin: high bypass, low decode, open test
// R10 - test mode uses external bit clock
// R11 - hold test, reframe, feed comma, ready marks boundary
// R12 - test or self-test reframe shows internal state
// R13 - checker unchanged in test mode
// R14 - ten bits form one character, decoded
// R15 - bit letters map to data bit numbers
// R16 - name Dxx.y or Kxx.y from bit groups
// R17 - reframe low freezes framer, ready awaits comma
// R18 - mismatch flag lasts exactly one byte
`ifndef SRB_CFG_SVH
`define SRB_CFG_SVH

// comma characters, decode constants and the framer bit count limit; bit a in the top position
`define SRB_K285_RDN     10'h0FA
`define SRB_K285_RDP     10'h305
`define SRB_K285_BYTE    8'hBC
`define SRB_VIOL_BYTE    8'hE0
`define SRB_K28_X        5'h1C
`define SRB_K28_Y5       3'h5
`define SRB_SIX_K28_RDN  6'h0F
`define SRB_SIX_K28_RDP  6'h30
`define SRB_CNT_LAST     4'h9
// one pattern loop is 256 characters, index 0 being the comma
`define SRB_VIOL_MASK    8'h3F
`define SRB_VIOL_SLOT    8'h20
`define SRB_LOOP_DATA    8'hFF
// host sequencing, in system clock cycles except SRB_TEST_HOLD and SRB_BIT_LAST, which count test clock falls
`define SRB_TCLK_HALF    4'h4
`define SRB_TEST_HOLD    8'h10
`define SRB_PRE_VIOL_CYC 16'h0190
`define SRB_BIT_LAST     4'h9

`endif

/* File: inc/srb_pkg.sv */
/*
  Types shared by both ends of the receiver test link.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package srb_pkg;

  // mode pin sense: high, low, or left open
  typedef enum logic [1:0] {
    SRB_MODE_DECODED = 2'b00,
    SRB_MODE_BYPASS  = 2'b01,
    SRB_MODE_TEST    = 2'b10
  } srb_mode_t;

  typedef enum logic [1:0] {
    SRB_BIST_IDLE = 2'b00,
    SRB_BIST_WAIT = 2'b01,
    SRB_BIST_RUN  = 2'b10
  } srb_bist_t;

  typedef enum logic [2:0] {
    SRB_H_IDLE  = 3'b000,
    SRB_H_PREV  = 3'b001,
    SRB_H_BIST  = 3'b010,
    SRB_H_THOLD = 3'b011,
    SRB_H_TSYNC = 3'b100,
    SRB_H_TRUN  = 3'b101
  } srb_host_t;

endpackage

/* File: inc/srb_link_if.sv */
/*
  Link between the receiver test logic and the host test logic.
  Assumes both ends run on the same system clock; serial and clock pins
  are resynchronised by the receiver.
*/
`timescale 1ns/1ps
`default_nettype none

interface srb_link_if;
  import srb_pkg::*;

  logic            serial_bit;
  logic            rec_bit_clk;
  logic            test_bit_clock_input;
  srb_mode_t       mode_sel;
  logic            self_test_enable_n;
  logic            reframe_enable;
  logic            send_violation_request;
  logic [7:0]      decoded_byte_out;
  logic            special_char_flag;
  logic            receive_violation_flag;
  logic [9:0]      raw_character_out;
  logic            ready_n;

  modport rx (
    input  serial_bit,
    input  rec_bit_clk,
    input  test_bit_clock_input,
    input  mode_sel,
    input  self_test_enable_n,
    input  reframe_enable,
    output decoded_byte_out,
    output special_char_flag,
    output receive_violation_flag,
    output raw_character_out,
    output ready_n
  );

  modport host (
    output serial_bit,
    output rec_bit_clk,
    output test_bit_clock_input,
    output mode_sel,
    output self_test_enable_n,
    output reframe_enable,
    output send_violation_request,
    input  decoded_byte_out,
    input  special_char_flag,
    input  receive_violation_flag,
    input  raw_character_out,
    input  ready_n
  );

endinterface

`default_nettype wire

/* File: core/srb_rx_end.sv */
/*
  Receiver end: framer, 8B/10B decode, self-test checker, mode selection.
  Assumes clk_sys runs well above the bit rate; the bit clocks and serial
  data arrive as pins and are resynchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
`include "srb_cfg.svh"

module srb_rx_end
  import srb_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rst_n,
  srb_link_if.rx    lnk,
  output logic      bist_active,
  output logic      bist_locked
);

  // ==========================================================
  // code tables (negative disparity column)
  function automatic logic [5:0] enc6(input logic [4:0] v);
    logic [5:0] c;
    c = 6'h00;
    unique case (v)
      5'd0:  c = 6'b100111;  5'd1:  c = 6'b011101;
      5'd2:  c = 6'b101101;  5'd3:  c = 6'b110001;
      5'd4:  c = 6'b110101;  5'd5:  c = 6'b101001;
      5'd6:  c = 6'b011001;  5'd7:  c = 6'b111000;
      5'd8:  c = 6'b111001;  5'd9:  c = 6'b100101;
      5'd10: c = 6'b010101;  5'd11: c = 6'b110100;
      5'd12: c = 6'b001101;  5'd13: c = 6'b101100;
      5'd14: c = 6'b011100;  5'd15: c = 6'b010111;
      5'd16: c = 6'b011011;  5'd17: c = 6'b100011;
      5'd18: c = 6'b010011;  5'd19: c = 6'b110010;
      5'd20: c = 6'b001011;  5'd21: c = 6'b101010;
      5'd22: c = 6'b011010;  5'd23: c = 6'b111010;
      5'd24: c = 6'b110011;  5'd25: c = 6'b100110;
      5'd26: c = 6'b010110;  5'd27: c = 6'b110110;
      5'd28: c = 6'b001110;  5'd29: c = 6'b101110;
      5'd30: c = 6'b011110;  5'd31: c = 6'b101011;
    endcase
    return c;
  endfunction

  function automatic logic [3:0] enc4(input logic [2:0] v);
    logic [3:0] c;
    c = 4'h0;
    unique case (v)
      3'd0: c = 4'b1011;  3'd1: c = 4'b1001;
      3'd2: c = 4'b0101;  3'd3: c = 4'b1100;
      3'd4: c = 4'b1101;  3'd5: c = 4'b1010;
      3'd6: c = 4'b0110;  3'd7: c = 4'b1110;
    endcase
    return c;
  endfunction

  // positive column: unbalanced codes invert, the balanced pair swaps
  function automatic logic [5:0] pos6(input logic [5:0] c);
    if (c == 6'b111000) return 6'b000111;
    if ($countones(c) != 3) return ~c;
    return c;
  endfunction

  function automatic logic [3:0] pos4(input logic [3:0] c);
    if (c == 4'b1100) return 4'b0011;
    if ($countones(c) != 2) return ~c;
    return c;
  endfunction

  function automatic logic rd6(input logic [5:0] c, input logic rd);
    if ($countones(c) > 3 || c == 6'b000111) return 1'b1;
    if ($countones(c) < 3 || c == 6'b111000) return 1'b0;
    return rd;
  endfunction

  function automatic logic rd4(input logic [3:0] c, input logic rd);
    if ($countones(c) > 2 || c == 4'b0011) return 1'b1;
    if ($countones(c) < 2 || c == 4'b1100) return 1'b0;
    return rd;
  endfunction

  // ==========================================================
  // pin synchronisers and bit strobe
  logic [2:0] pin_s1_r, pin_s2_r;
  logic       clk_prev_r;
  logic       test_mode, bist_on, decoded_op, sel_clk, bit_en;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_r <= 3'h0;
      pin_s2_r <= 3'h0;
    end else begin
      pin_s1_r <= {lnk.serial_bit, lnk.test_bit_clock_input,
                   lnk.rec_bit_clk};
      pin_s2_r <= pin_s1_r;
    end
  end

  // R9 mode pin decode
  assign test_mode  = (lnk.mode_sel == SRB_MODE_TEST);
  assign bist_on    = ~lnk.self_test_enable_n;
  // R8 bypass overridden by self-test
  assign decoded_op = (lnk.mode_sel != SRB_MODE_BYPASS) | bist_on;
  // R10 external bit clock in test mode
  assign sel_clk    = test_mode ? pin_s2_r[1] : pin_s2_r[0];
  assign bit_en     = sel_clk & ~clk_prev_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) clk_prev_r <= 1'b0;
    else        clk_prev_r <= sel_clk;
  end

  // ==========================================================
  // shifter and framer
  logic [9:0] sh_r, sh_nxt, ch_r;
  logic [3:0] cnt_r;
  logic       comma, char_done, ch_vld_r, rf_prev_r, inhib_r;

  assign sh_nxt    = {sh_r[8:0], pin_s2_r[2]};
  assign comma     = (sh_nxt == `SRB_K285_RDN) | (sh_nxt == `SRB_K285_RDP);
  // R14 ten bits per character; R17 realign only with reframe high
  assign char_done = bit_en & ((cnt_r == `SRB_CNT_LAST) |
                               (lnk.reframe_enable & comma));

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sh_r     <= 10'h000;
      cnt_r    <= 4'h0;
      ch_r     <= 10'h000;
      ch_vld_r <= 1'b0;
    end else begin
      ch_vld_r <= char_done;
      if (bit_en) begin
        sh_r  <= sh_nxt;
        cnt_r <= char_done ? 4'h0 : cnt_r + 4'h1;
      end
      if (char_done) ch_r <= sh_nxt;
    end
  end

  // ==========================================================
  // decoder
  logic       rd_r, rd_mid, rd_end, hit6, hit4, k28, dviol, k285;
  logic [4:0] dx;
  logic [2:0] dy;
  logic [7:0] dbyte;
  logic       dflag;

  // R15 bit a..e,i carry A..E; f..h,j carry F..H
  always_comb begin
    hit6 = 1'b0;
    hit4 = 1'b0;
    dx   = 5'h00;
    dy   = 3'h0;
    for (int v = 0; v < 32; v++) begin
      if (ch_r[9:4] == (rd_r ? pos6(enc6(5'(v))) : enc6(5'(v)))) begin
        hit6 = 1'b1;
        dx   = 5'(v);
      end
    end
    k28    = ch_r[9:4] == (rd_r ? `SRB_SIX_K28_RDP : `SRB_SIX_K28_RDN);
    rd_mid = rd6(ch_r[9:4], rd_r);
    for (int v = 0; v < 8; v++) begin
      // K28 tails invert the positive code when rd_mid is low
      if (ch_r[3:0] == (rd_mid ? pos4(enc4(3'(v))) :
                        k28 ? ~pos4(enc4(3'(v))) : enc4(3'(v)))) begin
        hit4 = 1'b1;
        dy   = 3'(v);
      end
    end
    // alternate x.7 form accepted loosely
    if (ch_r[3:0] == (rd_mid ? 4'b1000 : 4'b0111)) begin
      hit4 = 1'b1;
      dy   = 3'h7;
    end
    rd_end = rd4(ch_r[3:0], rd_mid);
    dviol  = ~(hit6 | k28) | ~hit4;
    k285   = k28 & hit4 & (dy == `SRB_K28_Y5);
    // R16 byte is HGF over EDCBA, flag marks K names
    if (dviol) begin
      dbyte = `SRB_VIOL_BYTE;
      dflag = 1'b1;
    end else if (k28) begin
      dbyte = {dy, `SRB_K28_X};
      dflag = 1'b1;
    end else begin
      dbyte = {dy, dx};
      dflag = 1'b0;
    end
  end

  // disparity follows every character, valid or not
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)        rd_r <= 1'b0;
    else if (ch_vld_r) rd_r <= rd_end;
  end

  // R17 ready held off from reframe rise until a comma; set wins
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rf_prev_r <= 1'b0;
      inhib_r   <= 1'b0;
    end else begin
      rf_prev_r <= lnk.reframe_enable;
      if (lnk.reframe_enable & ~rf_prev_r) inhib_r <= 1'b1;
      else if (ch_vld_r & k285)            inhib_r <= 1'b0;
    end
  end

  // ==========================================================
  // self-test checker
  srb_bist_t  bst_r;
  logic [7:0] idx_r, exp_byte;
  logic       exp_flag, exp_viol, mism;

  always_comb begin
    exp_viol = 1'b0;
    if (idx_r == 8'h00) begin
      exp_byte = `SRB_K285_BYTE;
      exp_flag = 1'b1;
    end else if ((idx_r & `SRB_VIOL_MASK) == `SRB_VIOL_SLOT) begin
      exp_byte = `SRB_VIOL_BYTE;
      exp_flag = 1'b1;
      exp_viol = 1'b1;
    end else begin
      exp_byte = idx_r;
      exp_flag = 1'b0;
    end
    mism = {dbyte, dflag, dviol} != {exp_byte, exp_flag, exp_viol};
  end

  // R1 comma starts the checker; R5 enable high returns to idle
  // R13 no dependence on the mode pin here
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bst_r <= SRB_BIST_IDLE;
      idx_r <= 8'h00;
    end else if (!bist_on) begin
      bst_r <= SRB_BIST_IDLE;
    end else if (ch_vld_r) begin
      unique case (bst_r)
        SRB_BIST_IDLE: bst_r <= SRB_BIST_WAIT;
        SRB_BIST_WAIT: begin
          if (k285) begin
            bst_r <= SRB_BIST_RUN;
            idx_r <= 8'h01;
          end
        end
        SRB_BIST_RUN:  idx_r <= idx_r + 8'h01;
        default:       bst_r <= SRB_BIST_IDLE;
      endcase
    end else if (bst_r == SRB_BIST_IDLE) begin
      bst_r <= SRB_BIST_WAIT;
    end
  end

  // ==========================================================
  // output stage with one character of lookahead for fill strings
  logic [7:0] hold_byte_r, byte_r;
  logic       hold_flag_r, hold_viol_r, hold_k285_r;
  logic       flag_r, viol_r, rdy_r, internal, rdy_nxt;
  logic [9:0] raw_r;

  // R12 internal state view
  assign internal = test_mode | (bist_on & lnk.reframe_enable);

  always_comb begin
    rdy_nxt = 1'b0;
    if (ch_vld_r) begin
      if (bst_r == SRB_BIST_RUN)
        // R3 missing low pulse at loop start
        rdy_nxt = (idx_r != 8'h00);
      else if (bst_r == SRB_BIST_WAIT)
        rdy_nxt = k285;
      // R11 the comma ending the hold-off marks the boundary
      else if (inhib_r)
        rdy_nxt = k285;
      else if (!decoded_op)
        rdy_nxt = ~lnk.reframe_enable | (ch_r == `SRB_K285_RDN) |
                  (ch_r == `SRB_K285_RDP);
      else
        rdy_nxt = ~(hold_k285_r & k285);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hold_byte_r <= 8'h00;
      hold_flag_r <= 1'b0;
      hold_viol_r <= 1'b0;
      hold_k285_r <= 1'b0;
      byte_r      <= 8'h00;
      flag_r      <= 1'b0;
      viol_r      <= 1'b0;
      raw_r       <= 10'h000;
      rdy_r       <= 1'b0;
    end else begin
      rdy_r <= rdy_nxt;
      if (ch_vld_r) begin
        hold_byte_r <= dbyte;
        hold_flag_r <= dflag;
        hold_viol_r <= dviol;
        hold_k285_r <= k285;
        raw_r       <= ch_r;
        if (internal) begin
          byte_r <= {bst_r, inhib_r, rd_r, cnt_r};
          flag_r <= k28;
          viol_r <= mism;
        end else if (bst_r == SRB_BIST_RUN) begin
          // R4 expected pattern shown
          byte_r <= exp_byte;
          flag_r <= exp_flag;
          // R2 R6 R18 one byte high per mismatch or planted violation
          viol_r <= mism | exp_viol;
        end else if (bst_r == SRB_BIST_WAIT) begin
          byte_r <= dbyte;
          flag_r <= dflag;
          viol_r <= dviol;
        end else begin
          byte_r <= hold_byte_r;
          flag_r <= hold_flag_r;
          viol_r <= hold_viol_r;
        end
      end
    end
  end

  // R9 raw character always on the bypass outputs
  assign lnk.raw_character_out      = raw_r;
  assign lnk.decoded_byte_out       = byte_r;
  assign lnk.special_char_flag      = flag_r;
  assign lnk.receive_violation_flag = viol_r;
  assign lnk.ready_n                = ~rdy_r;
  assign bist_active                = (bst_r != SRB_BIST_IDLE);
  assign bist_locked                = (bst_r == SRB_BIST_RUN);

endmodule

`default_nettype wire

/* File: core/srb_host_end.sv */
/*
  Host end: sequences self-test and factory test mode, counts progress.
  Assumes line_bit_in and line_clk_in come from the transmitter and the
  recovered clock, and that the receiver shares clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
`include "srb_cfg.svh"

module srb_host_end
  import srb_pkg::*;
#(
  parameter logic [15:0] PRE_VIOL_CYC = `SRB_PRE_VIOL_CYC
)
(
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  srb_link_if.host        lnk,
  input  wire logic       bist_start,
  input  wire logic       test_start,
  input  wire logic       stop_req,
  input  wire srb_mode_t  mode_cfg,
  input  wire logic       line_bit_in,
  input  wire logic       line_clk_in,
  output logic            bist_synced,
  output logic            test_aligned,
  output logic [15:0]     loop_count,
  output logic [15:0]     viol_count
);

  srb_host_t  st_r;
  logic [15:0] wait_r;
  logic [3:0]  div_r, bit_r;
  logic [7:0]  byte_cnt_r;
  logic        tclk_r, tbit_r, sbit_r, rclk_r, tfall, testing, pol_r;

  assign testing = (st_r == SRB_H_THOLD) | (st_r == SRB_H_TSYNC) |
                   (st_r == SRB_H_TRUN);
  assign tfall   = testing & tclk_r & (div_r == `SRB_TCLK_HALF);

  // ==========================================================
  // sequencer
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_r   <= SRB_H_IDLE;
      wait_r <= 16'h0000;
    end else if (stop_req) begin
      // R5 enable released on stop
      st_r <= SRB_H_IDLE;
    end else begin
      unique case (st_r)
        SRB_H_IDLE: begin
          if (bist_start) begin
            st_r   <= SRB_H_PREV;
            wait_r <= PRE_VIOL_CYC;
          end else if (test_start) begin
            st_r   <= SRB_H_THOLD;
            wait_r <= {8'h00, `SRB_TEST_HOLD};
          end
        end
        // R7 forced violations ahead of self-test
        SRB_H_PREV: begin
          if (wait_r == 16'h0000) st_r <= SRB_H_BIST;
          else                    wait_r <= wait_r - 16'h0001;
        end
        SRB_H_BIST: st_r <= SRB_H_BIST;
        // R11 hold test mode for some test clocks, then reframe
        SRB_H_THOLD: begin
          if (wait_r == 16'h0000)  st_r <= SRB_H_TSYNC;
          else if (tfall)          wait_r <= wait_r - 16'h0001;
        end
        SRB_H_TSYNC: if (!lnk.ready_n) st_r <= SRB_H_TRUN;
        SRB_H_TRUN:  st_r <= SRB_H_TRUN;
        default:     st_r <= SRB_H_IDLE;
      endcase
    end
  end

  // ==========================================================
  // test bit clock divider and comma bit source
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div_r  <= 4'h0;
      tclk_r <= 1'b0;
      bit_r  <= 4'h0;
      tbit_r <= 1'b0;
      pol_r  <= 1'b0;
    end else if (!testing) begin
      div_r  <= 4'h0;
      tclk_r <= 1'b0;
      bit_r  <= 4'h0;
    end else if (div_r == `SRB_TCLK_HALF) begin
      div_r  <= 4'h0;
      tclk_r <= ~tclk_r;
      // data changes on the falling edge, stable at the rising one
      // commas alternate in disparity so a wrong start disparity recovers
      if (tclk_r) begin
        tbit_r <= (st_r == SRB_H_THOLD) ? 1'b0 :
                  1'((pol_r ? `SRB_K285_RDP : `SRB_K285_RDN) >>
                     (`SRB_BIT_LAST - bit_r));
        bit_r  <= (bit_r == `SRB_BIT_LAST) ? 4'h0 : bit_r + 4'h1;
        if (bit_r == `SRB_BIT_LAST) pol_r <= ~pol_r;
      end
    end else begin
      div_r <= div_r + 4'h1;
    end
  end

  // line passthrough registered so clock and data keep their skew
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sbit_r <= 1'b0;
      rclk_r <= 1'b0;
    end else begin
      sbit_r <= testing ? tbit_r : line_bit_in;
      rclk_r <= line_clk_in;
    end
  end

  // ==========================================================
  // progress counters
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bist_synced  <= 1'b0;
      test_aligned <= 1'b0;
      byte_cnt_r   <= 8'h00;
      loop_count   <= 16'h0000;
      viol_count   <= 16'h0000;
    end else if (st_r == SRB_H_IDLE) begin
      bist_synced  <= 1'b0;
      test_aligned <= 1'b0;
      if (bist_start) begin
        loop_count <= 16'h0000;
        viol_count <= 16'h0000;
        byte_cnt_r <= 8'h00;
      end
    end else begin
      if (st_r == SRB_H_TSYNC && !lnk.ready_n) test_aligned <= 1'b1;
      if (st_r == SRB_H_BIST && !lnk.ready_n) begin
        // R1 first ready low marks the init code
        if (!bist_synced) begin
          bist_synced <= 1'b1;
        end else begin
          // R2 violation sampled once per byte
          if (lnk.receive_violation_flag)
            viol_count <= viol_count + 16'h0001;
          if (byte_cnt_r == `SRB_LOOP_DATA - 8'h01) begin
            byte_cnt_r <= 8'h00;
            loop_count <= loop_count + 16'h0001;
          end else begin
            byte_cnt_r <= byte_cnt_r + 8'h01;
          end
        end
      end
    end
  end

  assign lnk.serial_bit             = sbit_r;
  assign lnk.rec_bit_clk            = rclk_r;
  assign lnk.test_bit_clock_input   = tclk_r;
  // R9 R10 open pin selected while testing
  assign lnk.mode_sel               = testing ? SRB_MODE_TEST : mode_cfg;
  assign lnk.self_test_enable_n     = (st_r != SRB_H_BIST);
  assign lnk.reframe_enable         = (st_r == SRB_H_TSYNC) |
                                      (st_r == SRB_H_TRUN);
  assign lnk.send_violation_request = (st_r == SRB_H_PREV);

endmodule

`default_nettype wire

/* File: bench/srb_link_asserts.sv */
/*
  Checker on the link between receiver and host test logic.
  Assumes the bench instantiates it beside the link, by named connection.
*/
`timescale 1ns/1ps
`default_nettype none

module srb_link_asserts
  import srb_pkg::*;
#(
  parameter logic [15:0] PRE_VIOL_CYC = 16'h0004
)
(
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic       self_test_enable_n,
  input wire logic       reframe_enable,
  input wire logic       send_violation_request,
  input wire logic       test_bit_clock_input,
  input wire srb_mode_t  mode_sel,
  input wire logic [7:0] decoded_byte_out,
  input wire logic       special_char_flag,
  input wire logic       receive_violation_flag,
  input wire logic       ready_n
);
  logic [15:0] viol_cyc_r;
  logic        st_run;

  // checker display only holds outside test mode and reframing
  assign st_run = !self_test_enable_n && !reframe_enable &&
                  (mode_sel != SRB_MODE_TEST);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      viol_cyc_r <= 16'h0000;
    end else if (send_violation_request) begin
      viol_cyc_r <= viol_cyc_r + 16'h0001;
    end else begin
      viol_cyc_r <= 16'h0000;
    end
  end

  // ==========================================================
  // link properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  ready_pulse_a: assert property (!ready_n |=> ready_n)
    else $error("ready low longer than one cycle");
  test_reframe_a: assert property (
      reframe_enable |-> mode_sel == SRB_MODE_TEST)
    else $error("reframe outside test mode");
  test_hold_a: assert property (
      $rose(mode_sel == SRB_MODE_TEST) |-> !reframe_enable [*8])
    else $error("reframe too soon after test entry");
  bist_no_reframe_a: assert property (
      !self_test_enable_n |-> !reframe_enable)
    else $error("reframe during self-test");
  bist_after_viol_a: assert property (
      $fell(self_test_enable_n) |-> $past(send_violation_request))
    else $error("self-test without violations first");
  viol_len_a: assert property (
      $fell(send_violation_request) |->
      viol_cyc_r == PRE_VIOL_CYC + 16'h0001)
    else $error("violation request length wrong");
  // data pattern bytes other than BC and E0 show the flag low
  bist_flag_a: assert property (
      st_run && $past(st_run) && !ready_n && decoded_byte_out != 8'hBC &&
      decoded_byte_out != 8'hE0 |-> !special_char_flag)
    else $error("flag high on data pattern byte");
  test_clk_a: assert property (
      $rose(test_bit_clock_input) |->
      test_bit_clock_input [*5] ##1 !test_bit_clock_input)
    else $error("test clock half period wrong");

  cover property (!ready_n && st_run);
  cover property (!ready_n && reframe_enable);
  cover property (receive_violation_flag && !ready_n && st_run);
endmodule

`default_nettype wire

/* File: bench/serial_receiver_bist_and_test_modes_tb.sv */
/*
  Bench joining receiver and host ends; plays transmitter and host user.
  Assumes the design files and srb_cfg.svh are on the include path.
*/
`timescale 1ns/1ps
`default_nettype none
`include "srb_cfg.svh"

module serial_receiver_bist_and_test_modes_tb
  import srb_pkg::*;
;
  typedef struct packed {
    logic       d;
    logic [7:0] b;
    logic       f;
    logic       v;
  } srb_exp_t;

  localparam logic [15:0] PRE = 16'h0004;
  logic        clk_sys, rst_n, bist_start, test_start, stop_req, watch;
  logic        line_bit_in, line_clk_in, bist_active, bist_locked;
  logic        bist_synced, test_aligned;
  logic [15:0] loop_count, viol_count;
  srb_mode_t   mode_cfg;
  srb_exp_t    exp_q[$];
  srb_exp_t    e;
  int          errors, n_tests, cycles, k, n_chars;

  srb_link_if lnk ();
  srb_rx_end srb_rx_end_i (.clk_sys(clk_sys), .rst_n(rst_n), .lnk(lnk),
    .bist_active(bist_active), .bist_locked(bist_locked));
  srb_host_end #(.PRE_VIOL_CYC(PRE)) srb_host_end_i (.clk_sys(clk_sys),
    .rst_n(rst_n), .lnk(lnk), .bist_start(bist_start),
    .test_start(test_start), .stop_req(stop_req), .mode_cfg(mode_cfg),
    .line_bit_in(line_bit_in), .line_clk_in(line_clk_in),
    .bist_synced(bist_synced), .test_aligned(test_aligned),
    .loop_count(loop_count), .viol_count(viol_count));
  srb_link_asserts #(.PRE_VIOL_CYC(PRE)) srb_link_asserts_i (
    .clk_sys(clk_sys), .rst_n(rst_n),
    .self_test_enable_n(lnk.self_test_enable_n),
    .reframe_enable(lnk.reframe_enable),
    .send_violation_request(lnk.send_violation_request),
    .test_bit_clock_input(lnk.test_bit_clock_input),
    .mode_sel(lnk.mode_sel), .decoded_byte_out(lnk.decoded_byte_out),
    .special_char_flag(lnk.special_char_flag),
    .receive_violation_flag(lnk.receive_violation_flag),
    .ready_n(lnk.ready_n));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // ==========================================================
  // helpers
  task automatic check(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      errors++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // bit a first; line clock rises mid-bit, well below clk_sys/4
  task automatic send_char(input logic [9:0] c);
    for (int i = 9; i >= 0; i--) begin
      line_bit_in <= c[i];
      line_clk_in <= 1'b0;
      tick(5);
      line_clk_in <= 1'b1;
      tick(5);
    end
    line_clk_in <= 1'b0;
  endtask

  task automatic results();
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ==========================================================
  // output watcher: one note per ready pulse
  always @(posedge clk_sys) begin
    if (watch === 1'b1 && lnk.ready_n === 1'b0) begin
      if (exp_q.size() == 0) begin
        check(1'b0, "ready without note");
      end else begin
        e = exp_q.pop_front();
        if (e.d === 1'b1) begin
          check(lnk.decoded_byte_out === e.b && lnk.special_char_flag === e.f, "pattern");
          check(lnk.receive_violation_flag === e.v, "mismatch flag");
        end
      end
    end
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 8000) begin
      check(1'b0, "timeout");
      results();
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    rst_n = 1'b0;
    bist_start = 1'b0;
    test_start = 1'b0;
    stop_req = 1'b0;
    line_bit_in = 1'b0;
    line_clk_in = 1'b0;
    watch = 1'b0;
    mode_cfg = SRB_MODE_DECODED;
    void'($urandom(96));
    tick(3);
    rst_n <= 1'b1;
    for (k = 0; k < 3; k++) begin
      mode_cfg <= srb_mode_t'(k[1:0]);
      tick(2);
      check(lnk.mode_sel === mode_cfg, "mode pin");
    end
    // bypass must still check decoded pattern
    mode_cfg <= ($urandom % 2) ? SRB_MODE_BYPASS : SRB_MODE_DECODED;
    n_chars = 3 + $urandom % 4;
    bist_start <= 1'b1;
    tick(1);
    bist_start <= 1'b0;
    for (k = 0; k < 50 && lnk.self_test_enable_n !== 1'b0; k++) tick(1);
    check(lnk.self_test_enable_n === 1'b0, "no self-test");
    watch <= 1'b1;
    exp_q.push_back('{1'b0, 8'h00, 1'b0, 1'b0});
    // commas only: every run slot mismatches its index
    for (k = 0; k <= n_chars; k++) begin
      if (k > 0) exp_q.push_back('{1'b1, k[7:0], 1'b0, 1'b1});
      send_char(k[0] ? `SRB_K285_RDP : `SRB_K285_RDN);
    end
    tick(10);
    check(bist_synced === 1'b1 && bist_locked === 1'b1, "not synced");
    check(viol_count === 16'(n_chars) && loop_count === 16'h0000, "counts");
    check(lnk.raw_character_out === (n_chars[0] ? `SRB_K285_RDP : `SRB_K285_RDN), "raw");
    check(exp_q.size() == 0, "missing ready");
    check(lnk.mode_sel === mode_cfg, "mode lost");
    stop_req <= 1'b1;
    tick(1);
    stop_req <= 1'b0;
    tick(6);
    watch <= 1'b0;
    check(lnk.self_test_enable_n === 1'b1 && bist_active === 1'b0, "no exit");
    test_start <= 1'b1;
    tick(1);
    test_start <= 1'b0;
    for (k = 0; k < 3000 && test_aligned !== 1'b1; k++) tick(1);
    check(test_aligned === 1'b1, "no alignment");
    check(lnk.mode_sel === SRB_MODE_TEST && lnk.reframe_enable === 1'b1, "test pins");
    // stop in the low half so the test clock is not cut short
    @(negedge lnk.test_bit_clock_input);
    tick(1);
    stop_req <= 1'b1;
    tick(1);
    stop_req <= 1'b0;
    tick(2);
    check(lnk.reframe_enable === 1'b0 && lnk.mode_sel === mode_cfg, "test exit");
    results();
  end
endmodule

`default_nettype wire
